// ---- design/ccgr_pkg.sv ----
package ccgr_pkg;

    // register indices on the serial control port
    localparam logic [6:0] CCGR_ADDR_CTRL = 7'h14;
    localparam logic [6:0] CCGR_ADDR_PB1 = 7'h15;
    localparam logic [6:0] CCGR_ADDR_PB2 = 7'h16;
    localparam logic [6:0] CCGR_ADDR_PBVOL = 7'h17;
    localparam logic [6:0] CCGR_ADDR_RC1 = 7'h19;
    localparam logic [6:0] CCGR_ADDR_RC2 = 7'h1A;
    localparam logic [6:0] CCGR_ADDR_RCVOL = 7'h1B;
    // mapped registers share the upper address bits 0x2 or 0x3
    localparam logic [3:0] CCGR_ADDR_HI_LO = 4'h2;
    localparam logic [3:0] CCGR_ADDR_HI_HI = 4'h3;
    localparam logic [6:0] CCGR_ADDR_HOLE = 7'h18;

    // field positions
    localparam int CCGR_B_OPEN_DRAIN = 2;
    localparam int CCGR_B_FOUR_WIRE = 1;
    localparam int CCGR_B_AUTO_INC = 0;
    localparam int CCGR_B_GLOBAL_MUTE = 8;
    localparam int CCGR_B_SILENCE_MUTE = 4;
    localparam int CCGR_B_INVERT = 0;
    localparam int CCGR_B_RAMP = 4;
    localparam int CCGR_B_SHAPE = 0;
    localparam int CCGR_B_COMMIT = 12;
    localparam int CCGR_B_CH_MUTE = 8;
    localparam int CCGR_B_HPF_EN = 0;
    localparam int CCGR_B_CORNER_LO = 1;
    localparam int CCGR_B_GAIN_LO = 0;

    // values after reset
    localparam logic CCGR_RST_OPEN_DRAIN = 1'b0;
    localparam logic CCGR_RST_FOUR_WIRE = 1'b1;
    localparam logic CCGR_RST_AUTO_INC = 1'b0;
    localparam logic CCGR_RST_GLOBAL_MUTE = 1'b1;
    localparam logic CCGR_RST_SILENCE_MUTE = 1'b1;
    localparam logic CCGR_RST_INVERT = 1'b0;
    localparam logic CCGR_RST_RAMP = 1'b1;
    localparam logic CCGR_RST_SHAPE = 1'b0;
    localparam logic CCGR_RST_CH_MUTE = 1'b0;
    localparam logic [7:0] CCGR_RST_GAIN = 8'hC0;
    localparam logic [1:0] CCGR_RST_CORNER = 2'h0;
    localparam logic CCGR_RST_HPF_EN = 1'b0;

    // serial frame: r/w flag, 7 address bits, 16 data bits, msb first
    localparam logic [4:0] CCGR_CMD_LAST = 5'h07;
    localparam logic [4:0] CCGR_FRAME_LAST = 5'h17;
    localparam int CCGR_DATA_W = 16;
    localparam int CCGR_WORD_W = 23;

    typedef enum logic [1:0] {
        CCGR_LK_CMD = 2'b00,
        CCGR_LK_DATA = 2'b01,
        CCGR_LK_DONE = 2'b11
    } ccgr_link_state_t;

endpackage

// ---- design/ccgr_link.sv ----
`timescale 1ns/100ps
// serial side of the control port, clocked by the host's serial clock
module ccgr_link import ccgr_pkg::*; (
    input wire logic link_clk,
    input wire logic rstn,
    input wire logic sel_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic readout_out,
    output logic readout_oe,
    input wire logic four_wire_lvl,
    input wire logic open_drain_lvl,
    input wire logic [7:0][15:0] rd_image,
    output logic wr_tgl,
    output logic [CCGR_WORD_W-1:0] wr_word
);

    typedef struct packed {
        ccgr_link_state_t st;
        logic [4:0] cnt;
        logic [14:0] shift;
        logic rd;
        logic [6:0] addr;
        logic [15:0] rd_word;
        logic [1:0] fw_sync;
        logic [1:0] od_sync;
    } ccgr_link_reg_t;

    localparam ccgr_link_reg_t LINK_RST = '{st: CCGR_LK_CMD, cnt: 5'h00, shift: 15'h0000,
        rd: 1'b0, addr: 7'h00, rd_word: 16'h0000, fw_sync: {2{CCGR_RST_FOUR_WIRE}},
        od_sync: {2{CCGR_RST_OPEN_DRAIN}}};

    ccgr_link_reg_t lk_r;
    ccgr_link_reg_t lk_nxt;
    logic [7:0] cmd;
    logic mapped;
    logic commit;
    logic drive_bit;
    logic drive_en;
    logic [3:0] bit_idx;

    assign cmd = {lk_r.shift[6:0], sda_in};
    // only the seven real indices read back; neighbours would alias the low bits
    assign mapped = cmd[6:0] >= CCGR_ADDR_CTRL && cmd[6:0] <= CCGR_ADDR_RCVOL
        && cmd[6:0] != CCGR_ADDR_HOLE;
    assign commit = lk_r.st == CCGR_LK_DATA && lk_r.cnt == CCGR_FRAME_LAST && !lk_r.rd;
    assign bit_idx = 4'(CCGR_FRAME_LAST - lk_r.cnt);

    // bit counter, shifter and command decode
    always_comb begin
        lk_nxt = lk_r;
        lk_nxt.fw_sync = {lk_r.fw_sync[0], four_wire_lvl};
        lk_nxt.od_sync = {lk_r.od_sync[0], open_drain_lvl};
        lk_nxt.shift = {lk_r.shift[13:0], sda_in};
        lk_nxt.cnt = 5'(lk_r.cnt + 5'h01);
        case (lk_r.st)
            CCGR_LK_CMD: begin
                if (lk_r.cnt == CCGR_CMD_LAST) begin
                    lk_nxt.st = CCGR_LK_DATA;
                    lk_nxt.rd = cmd[7];
                    lk_nxt.addr = cmd[6:0];
                    // quasi-static image: core only changes it after a write frame
                    lk_nxt.rd_word = mapped ? rd_image[cmd[2:0]] : 16'h0000;
                end
            end
            CCGR_LK_DATA: begin
                if (lk_r.cnt == CCGR_FRAME_LAST) begin
                    lk_nxt.st = CCGR_LK_DONE;
                end
            end
            CCGR_LK_DONE: begin
                lk_nxt.cnt = lk_r.cnt; // extra clocks are ignored
            end
            default: begin
                lk_nxt.st = CCGR_LK_CMD;
            end
        endcase
    end

    // frame state clears whenever select is released
    always_ff @(posedge link_clk or posedge sel_n) begin
        if (sel_n) begin
            lk_r <= LINK_RST;
        end else begin
            lk_r <= lk_nxt;
        end
    end

    // write hold word and its toggle survive between frames
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            wr_tgl <= 1'b0;
            wr_word <= '0;
        end else if (commit) begin
            wr_tgl <= ~wr_tgl;
            wr_word <= {lk_r.addr, lk_r.shift, sda_in};
        end
    end

    assign drive_en = lk_r.st == CCGR_LK_DATA && lk_r.rd;
    assign drive_bit = lk_r.rd_word[bit_idx];

    // read data launched on the falling edge; pins released outside frames
    always_ff @(negedge link_clk or posedge sel_n) begin
        if (sel_n) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            readout_out <= 1'b0;
            readout_oe <= 1'b0;
        end else begin
            sda_out <= drive_bit;
            sda_oe <= drive_en && !lk_r.fw_sync[1];
            readout_out <= lk_r.od_sync[1] ? 1'b0 : drive_bit;
            readout_oe <= drive_en && lk_r.fw_sync[1]
                && !(lk_r.od_sync[1] && drive_bit);
        end
    end

endmodule // ccgr_link

// ---- design/ccgr_regs.sv ----
// Behaviour
// - Control bit 2: read-data pin push-pull when 0, open drain when 1, four-wire only.
// - Control bit 1 resets to 1: 0 three-wire on data pin, 1 four-wire readout pin.
// - Control bit 0 enables address auto-increment for two-wire mode; resets disabled.
// - Playback bit 8 resets 1 and mutes all playback; bit 4 auto-mute, resets enabled.
// - Playback bit 0 inverts left playback output when set; resets clear.
// - Second playback register bit 4 enables volume ramping; resets enabled.
// - Second playback register bit 0: 0 normal filter, 1 sloping stopband; resets 0.
// - Writing 1 to bit 12 of left playback volume applies the programmed volume.
// - Left playback volume bit 8 mutes left playback; resets clear.
// - Left playback 8-bit volume resets to 0dB code; zero mutes, steps of 0.375dB.
// - Record bit 8 resets 1 and mutes all record channels.
// - Record bit 0 inverts left record output when set; resets clear.
// - Two-bit record high-pass corner resets 00: 4Hz first order, else second order.
// - Second record register bit 0 enables record high-pass; resets disabled.
// - Writing 1 to bit 12 of left record volume applies the programmed volume.
// - Left record volume bit 8 mutes left record; resets clear.
// - Left record 8-bit volume resets to 0dB code; zero mutes, steps of 0.375dB.
`timescale 1ns/100ps
module ccgr_regs import ccgr_pkg::*; (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic link_clk,
    input wire logic sel_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic serial_readout_pin_out,
    output logic serial_readout_pin_oe,
    output logic readout_open_drain_sel,
    output logic four_wire_mode_sel,
    output logic addr_auto_inc,
    output logic playback_silence_mute,
    output logic playback_left_invert,
    output logic playback_ramp_enable,
    output logic playback_filter_shape,
    output logic playback_left_muted,
    output logic [7:0] playback_left_gain,
    output logic record_left_invert,
    output logic [1:0] record_highpass_corner,
    output logic record_highpass_enable,
    output logic record_left_muted,
    output logic [7:0] record_left_gain
);

    typedef struct packed {
        logic [2:0] tsync;
        logic open_drain;
        logic four_wire;
        logic auto_inc;
        logic pb_gmute;
        logic pb_smute;
        logic pb_inv;
        logic pb_ramp;
        logic pb_shape;
        logic pb_mute;
        logic [7:0] pb_pend;
        logic [7:0] pb_act;
        logic pb_muted;
        logic rc_gmute;
        logic rc_inv;
        logic [1:0] rc_corner;
        logic rc_hpf;
        logic rc_mute;
        logic [7:0] rc_pend;
        logic [7:0] rc_act;
        logic rc_muted;
        logic [7:0][15:0] img;
    } ccgr_core_t;

    localparam ccgr_core_t CORE_RST = '{tsync: 3'h0, open_drain: CCGR_RST_OPEN_DRAIN,
        four_wire: CCGR_RST_FOUR_WIRE, auto_inc: CCGR_RST_AUTO_INC,
        pb_gmute: CCGR_RST_GLOBAL_MUTE, pb_smute: CCGR_RST_SILENCE_MUTE,
        pb_inv: CCGR_RST_INVERT, pb_ramp: CCGR_RST_RAMP, pb_shape: CCGR_RST_SHAPE,
        pb_mute: CCGR_RST_CH_MUTE, pb_pend: CCGR_RST_GAIN, pb_act: CCGR_RST_GAIN,
        pb_muted: 1'b1, rc_gmute: CCGR_RST_GLOBAL_MUTE, rc_inv: CCGR_RST_INVERT,
        rc_corner: CCGR_RST_CORNER, rc_hpf: CCGR_RST_HPF_EN, rc_mute: CCGR_RST_CH_MUTE,
        rc_pend: CCGR_RST_GAIN, rc_act: CCGR_RST_GAIN, rc_muted: 1'b1, img: '0};

    ccgr_core_t st_r;
    ccgr_core_t st_nxt;
    logic wr_tgl;
    logic [CCGR_WORD_W-1:0] wr_word;
    logic [6:0] wr_addr;
    logic [CCGR_DATA_W-1:0] wr_data;
    logic wr_take;

    // serial engine on the host's clock
    ccgr_link u_link (
        .link_clk(link_clk),
        .rstn(rstn),
        .sel_n(sel_n),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .readout_out(serial_readout_pin_out),
        .readout_oe(serial_readout_pin_oe),
        .four_wire_lvl(st_r.four_wire),
        .open_drain_lvl(st_r.open_drain),
        .rd_image(st_r.img),
        .wr_tgl(wr_tgl),
        .wr_word(wr_word)
    );

    // hold word is stable once the synchronised toggle changes
    assign wr_take = st_r.tsync[2] ^ st_r.tsync[1];
    assign wr_addr = wr_word[CCGR_WORD_W-1:CCGR_DATA_W];
    assign wr_data = wr_word[CCGR_DATA_W-1:0];

    // register writes, commit logic and read-back image
    always_comb begin
        st_nxt = st_r;
        st_nxt.tsync = {st_r.tsync[1:0], wr_tgl};
        if (wr_take) begin
            case (wr_addr)
                CCGR_ADDR_CTRL: begin
                    st_nxt.open_drain = wr_data[CCGR_B_OPEN_DRAIN];
                    st_nxt.four_wire = wr_data[CCGR_B_FOUR_WIRE];
                    st_nxt.auto_inc = wr_data[CCGR_B_AUTO_INC];
                end
                CCGR_ADDR_PB1: begin
                    st_nxt.pb_gmute = wr_data[CCGR_B_GLOBAL_MUTE];
                    st_nxt.pb_smute = wr_data[CCGR_B_SILENCE_MUTE];
                    st_nxt.pb_inv = wr_data[CCGR_B_INVERT];
                end
                CCGR_ADDR_PB2: begin
                    st_nxt.pb_ramp = wr_data[CCGR_B_RAMP];
                    st_nxt.pb_shape = wr_data[CCGR_B_SHAPE];
                end
                CCGR_ADDR_PBVOL: begin
                    st_nxt.pb_mute = wr_data[CCGR_B_CH_MUTE];
                    st_nxt.pb_pend = wr_data[CCGR_B_GAIN_LO +: 8];
                    if (wr_data[CCGR_B_COMMIT]) begin
                        st_nxt.pb_act = wr_data[CCGR_B_GAIN_LO +: 8];
                    end
                end
                CCGR_ADDR_RC1: begin
                    st_nxt.rc_gmute = wr_data[CCGR_B_GLOBAL_MUTE];
                    st_nxt.rc_inv = wr_data[CCGR_B_INVERT];
                end
                CCGR_ADDR_RC2: begin
                    st_nxt.rc_corner = wr_data[CCGR_B_CORNER_LO +: 2];
                    st_nxt.rc_hpf = wr_data[CCGR_B_HPF_EN];
                end
                CCGR_ADDR_RCVOL: begin
                    st_nxt.rc_mute = wr_data[CCGR_B_CH_MUTE];
                    st_nxt.rc_pend = wr_data[CCGR_B_GAIN_LO +: 8];
                    if (wr_data[CCGR_B_COMMIT]) begin
                        st_nxt.rc_act = wr_data[CCGR_B_GAIN_LO +: 8];
                    end
                end
                default: begin
                    st_nxt.tsync = {st_r.tsync[1:0], wr_tgl}; // unmapped writes dropped
                end
            endcase
        end
        // gain code zero is itself a mute on the path
        st_nxt.pb_muted = st_nxt.pb_gmute || st_nxt.pb_mute || st_nxt.pb_act == 8'h00;
        st_nxt.rc_muted = st_nxt.rc_gmute || st_nxt.rc_mute || st_nxt.rc_act == 8'h00;
        // read image indexed by low address bits; commit bits read back zero
        st_nxt.img = '0;
        st_nxt.img[CCGR_ADDR_CTRL[2:0]][CCGR_B_OPEN_DRAIN] = st_nxt.open_drain;
        st_nxt.img[CCGR_ADDR_CTRL[2:0]][CCGR_B_FOUR_WIRE] = st_nxt.four_wire;
        st_nxt.img[CCGR_ADDR_CTRL[2:0]][CCGR_B_AUTO_INC] = st_nxt.auto_inc;
        st_nxt.img[CCGR_ADDR_PB1[2:0]][CCGR_B_GLOBAL_MUTE] = st_nxt.pb_gmute;
        st_nxt.img[CCGR_ADDR_PB1[2:0]][CCGR_B_SILENCE_MUTE] = st_nxt.pb_smute;
        st_nxt.img[CCGR_ADDR_PB1[2:0]][CCGR_B_INVERT] = st_nxt.pb_inv;
        st_nxt.img[CCGR_ADDR_PB2[2:0]][CCGR_B_RAMP] = st_nxt.pb_ramp;
        st_nxt.img[CCGR_ADDR_PB2[2:0]][CCGR_B_SHAPE] = st_nxt.pb_shape;
        st_nxt.img[CCGR_ADDR_PBVOL[2:0]][CCGR_B_CH_MUTE] = st_nxt.pb_mute;
        st_nxt.img[CCGR_ADDR_PBVOL[2:0]][CCGR_B_GAIN_LO +: 8] = st_nxt.pb_pend;
        st_nxt.img[CCGR_ADDR_RC1[2:0]][CCGR_B_GLOBAL_MUTE] = st_nxt.rc_gmute;
        st_nxt.img[CCGR_ADDR_RC1[2:0]][CCGR_B_INVERT] = st_nxt.rc_inv;
        st_nxt.img[CCGR_ADDR_RC2[2:0]][CCGR_B_CORNER_LO +: 2] = st_nxt.rc_corner;
        st_nxt.img[CCGR_ADDR_RC2[2:0]][CCGR_B_HPF_EN] = st_nxt.rc_hpf;
        st_nxt.img[CCGR_ADDR_RCVOL[2:0]][CCGR_B_CH_MUTE] = st_nxt.rc_mute;
        st_nxt.img[CCGR_ADDR_RCVOL[2:0]][CCGR_B_GAIN_LO +: 8] = st_nxt.rc_pend;
    end

    // single state register of the core side
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= CORE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // settings towards the audio paths and the control port
    assign readout_open_drain_sel = st_r.open_drain;
    assign four_wire_mode_sel = st_r.four_wire;
    assign addr_auto_inc = st_r.auto_inc;
    assign playback_silence_mute = st_r.pb_smute;
    assign playback_left_invert = st_r.pb_inv;
    assign playback_ramp_enable = st_r.pb_ramp;
    assign playback_filter_shape = st_r.pb_shape;
    assign playback_left_muted = st_r.pb_muted;
    assign playback_left_gain = st_r.pb_act;
    assign record_left_invert = st_r.rc_inv;
    assign record_highpass_corner = st_r.rc_corner;
    assign record_highpass_enable = st_r.rc_hpf;
    assign record_left_muted = st_r.rc_muted;
    assign record_left_gain = st_r.rc_act;

endmodule // ccgr_regs

// ---- dv/ccgr_host.sv ----
`timescale 1ns/100ps
// host side of the serial control port; its clock runs only inside frames
module ccgr_host (
    output logic link_clk,
    output logic sel_n,
    output logic sda_drv,
    input wire logic sda_wire,
    input wire logic ro_wire
);
    logic [15:0] rd_q;
    event rd_ev;
    // idle levels before any frame
    initial begin
        link_clk = 1'b0;
        sel_n = 1'b0;
        sda_drv = 1'b1;
        #1 sel_n = 1'b1; // a real rising edge clears the frame logic
    end
    // one frame, msb first; fewer than 24 clocks aborts it
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d,
        input logic fw, input int nbits);
        logic [23:0] w;
        w = {rd, a, d};
        #3.3 sel_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sda_drv = (rd && i > 7) ? ~sda_drv : w[23-i]; // released line keeps moving
            #7.5 link_clk = 1'b1;
            if (i > 7) rd_q[23-i] = fw ? ro_wire : sda_wire;
            #7.5 link_clk = 1'b0;
        end
        #7.5 sel_n = 1'b1;
        sda_drv = ~sda_drv;
        #15;
        if (rd) -> rd_ev;
    endtask
endmodule // ccgr_host

// ---- dv/ccgr_regs_checker.sv ----
`timescale 1ns/100ps
module ccgr_regs_checker (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sel_n,
    input wire logic sda_oe,
    input wire logic serial_readout_pin_out,
    input wire logic serial_readout_pin_oe,
    input wire logic readout_open_drain_sel,
    input wire logic four_wire_mode_sel,
    input wire logic addr_auto_inc,
    input wire logic playback_silence_mute,
    input wire logic playback_left_invert,
    input wire logic playback_ramp_enable,
    input wire logic playback_filter_shape,
    input wire logic playback_left_muted,
    input wire logic [7:0] playback_left_gain,
    input wire logic record_left_invert,
    input wire logic [1:0] record_highpass_corner,
    input wire logic record_highpass_enable,
    input wire logic record_left_muted,
    input wire logic [7:0] record_left_gain
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // values right after reset
    chk_reset_vals: assert property ($rose(rstn) |->
        playback_left_gain == 8'hC0 && record_left_gain == 8'hC0 && four_wire_mode_sel
        && playback_silence_mute && playback_ramp_enable && !addr_auto_inc
        && playback_left_muted && record_left_muted) else $error("bad values after reset");
    // gain code zero counts as mute
    chk_pb_zero: assert property ((playback_left_gain == 8'h00) [*2] |->
        playback_left_muted) else $error("playback gain zero not muted");
    chk_rc_zero: assert property ((record_left_gain == 8'h00) [*2] |->
        record_left_muted) else $error("record gain zero not muted");
    // without frames nothing moves
    chk_pb_hold: assert property (sel_n [*6] |=> $stable({playback_silence_mute,
        playback_left_invert, playback_ramp_enable, playback_filter_shape,
        playback_left_muted, playback_left_gain})) else $error("playback changed idle");
    chk_rc_hold: assert property (sel_n [*6] |=> $stable({record_left_invert,
        record_highpass_corner, record_highpass_enable, record_left_muted, record_left_gain,
        readout_open_drain_sel, four_wire_mode_sel, addr_auto_inc}))
        else $error("record or control changed idle");
    // pins let go outside frames
    chk_sda_free: assert property (sel_n [*2] |-> !sda_oe)
        else $error("data pin driven outside frame");
    chk_ro_free: assert property (sel_n [*2] |-> !serial_readout_pin_oe)
        else $error("readout pin driven outside frame");
    // open drain only pulls low
    chk_od_low: assert property (!sel_n && readout_open_drain_sel && serial_readout_pin_oe
        |-> !serial_readout_pin_out) else $error("open drain drove high");
    // mode picks the pin
    chk_three_wire: assert property (!sel_n && !four_wire_mode_sel |->
        !serial_readout_pin_oe) else $error("readout pin used in three-wire mode");
    chk_four_wire: assert property (!sel_n && four_wire_mode_sel |-> !sda_oe)
        else $error("data pin driven in four-wire mode");
endmodule // ccgr_regs_checker
bind ccgr_regs ccgr_regs_checker chk (.*);

// ---- dv/ccgr_regs_bench.sv ----
`timescale 1ns/100ps
module ccgr_regs_bench import ccgr_pkg::*; ();
    logic core_clk, rstn, link_clk, sel_n, sda_drv, sda_in, ro_wire, fw;
    logic sda_out, sda_oe, serial_readout_pin_out, serial_readout_pin_oe;
    logic readout_open_drain_sel, four_wire_mode_sel, addr_auto_inc, playback_silence_mute;
    logic playback_left_invert, playback_ramp_enable, playback_filter_shape, playback_left_muted;
    logic record_left_invert, record_highpass_enable, record_left_muted;
    logic [7:0] playback_left_gain, record_left_gain, pg, rg;
    logic [1:0] record_highpass_corner;
    logic [15:0] exp_q[$];
    int bad_count, total_checks;
    logic [6:0] adr [7] = '{CCGR_ADDR_CTRL, CCGR_ADDR_PB1, CCGR_ADDR_PB2, CCGR_ADDR_PBVOL,
        CCGR_ADDR_RC1, CCGR_ADDR_RC2, CCGR_ADDR_RCVOL};
    logic [15:0] msk [7] = '{16'h0007, 16'h0111, 16'h0011, 16'h01FF, 16'h0101, 16'h0007, 16'h01FF};
    logic [15:0] img [7] = '{16'h0002, 16'h0110, 16'h0010, 16'h00C0, 16'h0100, 16'h0000, 16'h00C0};
    // index and data of directed writes
    logic [19:0] dir [18] = '{20'h30033, 20'h31033, 20'h31000, 20'h10000, 20'h31140, 20'h31040,
        20'h610FF, 20'h40000, 20'h61001, 20'h60100, 20'h61000, 20'h50002, 20'h50004,
        20'h50007, 20'h20011, 20'h00007, 20'h00000, 20'h00002};
    wire [15:0] ct_o = {13'h0, readout_open_drain_sel, four_wire_mode_sel, addr_auto_inc};
    wire [15:0] pb_o = {3'h0, playback_silence_mute, playback_left_invert, playback_ramp_enable,
        playback_filter_shape, playback_left_muted, playback_left_gain};
    wire [15:0] rc_o = {3'h0, record_left_invert, record_highpass_corner,
        record_highpass_enable, record_left_muted, record_left_gain};
    // wire levels: host releases data pin while the device drives it
    assign sda_in = sda_oe ? sda_out : sda_drv;
    assign ro_wire = serial_readout_pin_oe ? serial_readout_pin_out
        : (readout_open_drain_sel ? 1'b1 : ~serial_readout_pin_out);
    ccgr_regs dut (.*);
    ccgr_host host (.link_clk(link_clk), .sel_n(sel_n), .sda_drv(sda_drv),
        .sda_wire(sda_in), .ro_wire(ro_wire));
    // core clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // read results are matched against the oldest note
    always @(host.rd_ev) cmp(host.rd_q, exp_q.pop_front(), "read");
    task automatic settle();
        repeat (8) @(posedge core_clk);
        #2;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.xfer(1'b1, a, 16'h0000, fw, 24);
        settle();
    endtask
    // write one register and track what it should hold
    task automatic wr(input int i, input logic [15:0] d);
        host.xfer(1'b0, adr[i], d, fw, 24);
        img[i] = d & msk[i];
        if (i == 3 && d[12]) pg = d[7:0];
        if (i == 6 && d[12]) rg = d[7:0];
        if (i == 0) fw = d[1];
        settle();
    endtask
    task automatic chk_all(input string name);
        logic [15:0] pe;
        logic [15:0] re;
        pe = {3'h0, img[1][4], img[1][0], img[2][4], img[2][0],
            img[1][8] | img[3][8] | (pg == 8'h00), pg};
        re = {3'h0, img[4][0], img[5][2:1], img[5][0],
            img[4][8] | img[6][8] | (rg == 8'h00), rg};
        for (int i = 0; i < 7; i++) rd_chk(adr[i], img[i]);
        cmp(ct_o, img[0], "ctrl");
        cmp(pb_o, pe, "play");
        cmp(rc_o, re, "rec");
        $display("test %s done", name);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #2000000;
        bad_count++;
        end_of_test();
    end
    // main sequence
    initial begin
        rstn = 1'b1;
        fw = 1'b1;
        pg = 8'hC0;
        rg = 8'hC0;
        void'($urandom(32'hC01D));
        #1 rstn = 1'b0; // a real falling edge, so every flop reset by rstn sees it
        repeat (10) @(posedge core_clk);
        #2 rstn = 1'b1;
        settle();
        chk_all("reset");
        for (int k = 0; k < 18; k++) begin
            wr(dir[k][19:16], dir[k][15:0]);
            chk_all("directed");
        end
        // second reset in mid-run brings every setting back
        rstn = 1'b0;
        repeat (2) @(posedge core_clk);
        #2 rstn = 1'b1;
        img = '{16'h0002, 16'h0110, 16'h0010, 16'h00C0, 16'h0100, 16'h0000, 16'h00C0};
        fw = 1'b1;
        pg = 8'hC0;
        rg = 8'hC0;
        settle();
        chk_all("reset again");
        for (int k = 0; k < 6; k++) begin
            wr($urandom_range(1, 6), 16'($urandom));
            chk_all("random");
        end
        host.xfer(1'b0, CCGR_ADDR_HOLE, 16'hFFFF, fw, 24);
        settle();
        rd_chk(CCGR_ADDR_HOLE, 16'h0000);
        rd_chk(7'h11, 16'h0000);
        rd_chk(7'h1C, 16'h0000);
        // a cut frame carrying the inverse must leave the register alone
        host.xfer(1'b0, CCGR_ADDR_PB2, ~img[2], fw, 20);
        settle();
        chk_all("refused");
        end_of_test();
    end
endmodule // ccgr_regs_bench
